// ===== core/mdsm_pkg.sv
// Package of constants, types and register map for the main loop state machine
//------------------------------------------------------------------------------
// Notes on behaviour
// - With build-out on or frequency limit under 30 ppm, limit switch phase slope.
// - Six states: free-run, locked, holdover, prelocked, prelocked 2, loss-of-lock.
// - Software may force any state through the first mode control register.
// - Every state change sets a latched bit; enabled, it raises an interrupt request.
// - Current state is readable in the operating state register.
// - Reset leaves the machine in free-run on the local oscillator.
// - Free-run goes to prelocked as soon as any input with nonzero priority is valid.
// - Prelocked waits the programmable timeout; two seconds of lock gives locked.
// - Prelocked timeout flags lock alarm, invalidates input, retries or falls to free-run.
// - Revertive: better input valid during prelocked restarts prelocked on it.
// - Locked is entered after two seconds of lock from the three acquiring states.
// - With pin enable set, the sync pin is high while locked.
// - Locked: activity loss invalidates; prelocked 2 at once or holdover after 2 s.
// - Loss of phase lock while locked moves at once to loss-of-lock.
// - Loss-of-lock retries for the timeout; two seconds of lock returns to locked.
// - Loss-of-lock: activity loss, after 2 s invalid, prelocked 2 or holdover.
// - Loss-of-lock timeout flags lock alarm, invalidates, prelocked 2 or holdover.
// - Prelocked 2 waits the timeout; two seconds of lock gives locked.
// - Prelocked 2 timeout flags alarm, invalidates, retries or goes to holdover.
// - Revertive: better input valid during prelocked 2 restarts prelocked 2 on it.
// - Valid means no activity alarm and no lock alarm; lock checked on selected only.
// - Phase lock is declared after one to two seconds of unbroken loop lock.
// - Holdover goes at once to prelocked 2 when any input with nonzero priority is valid.
//------------------------------------------------------------------------------
package mdsm_pkg;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned SECOND_NS = 1000000000;
  localparam int unsigned SEC_CYCLES = SECOND_NS / CLK_PERIOD_NS;
  localparam int unsigned QUAL_SECS = 2;
  localparam int unsigned DECLARE_SECS = 2;
  localparam logic [15:0] TIMEOUT_RST = 16'h0064;
  localparam logic [7:0] SLEW_PPM_LIMIT = 8'h1E;
  localparam logic [7:0] FREQ_LIMIT_RST = 8'h09;

  // Register offsets
  localparam logic [7:0] OFS_MODE_FIRST = 8'h00;
  localparam logic [7:0] OFS_MODE_THIRD = 8'h04;
  localparam logic [7:0] OFS_MODE_TENTH = 8'h08;
  localparam logic [7:0] OFS_FREQ_LIMIT = 8'h0C;
  localparam logic [7:0] OFS_TIMEOUT = 8'h10;
  localparam logic [7:0] OFS_OPERATING_STATE_REG = 8'h14;
  localparam logic [7:0] OFS_LATCHED = 8'h18;
  localparam logic [7:0] OFS_ALARMS = 8'h1C;
  localparam logic [7:0] OFS_VALID = 8'h20;
  localparam logic [7:0] OFS_IRQ_EN = 8'h24;
  localparam logic [7:0] OFS_PRIO = 8'h28;
  localparam logic [7:0] OFS_SELREF = 8'h2C;

  // Field positions
  localparam int unsigned FORCE_EN_BIT = 3;
  localparam int unsigned SYNC_PIN_BIT = 4;
  localparam int unsigned PRIO_W = 4;

  // State codes as seen by software
  localparam logic [2:0] CODE_FREE = 3'h1;
  localparam logic [2:0] CODE_HOLD = 3'h2;
  localparam logic [2:0] CODE_LOCK = 3'h4;
  localparam logic [2:0] CODE_PRE2 = 3'h5;
  localparam logic [2:0] CODE_PRE = 3'h6;
  localparam logic [2:0] CODE_LOL = 3'h7;

  typedef enum logic [5:0] {
    ST_FREE = 6'h01,
    ST_PRE = 6'h02,
    ST_PRE2 = 6'h04,
    ST_LOCK = 6'h08,
    ST_LOL = 6'h10,
    ST_HOLD = 6'h20
  } mdsm_state_t;

  // Software configuration bundle
  typedef struct packed {
    logic force_en;
    logic [2:0] force_code;
    logic sync_pin_enable;
    logic return_to_best_enable;
    logic phase_buildout_enable;
    logic [7:0] freq_limit_setting;
    logic [15:0] timeout_secs;
    logic irq_en;
  } mdsm_cfg_t;

endpackage : mdsm_pkg

// ===== core/mdsm_main_loop.sv
// Control state machine of the main digital loop with its register port
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module mdsm_main_loop #(
  parameter int unsigned NUM_IN = 4,
  parameter int unsigned SEC_CYCLES = mdsm_pkg::SEC_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Monitors
  input wire logic [NUM_IN-1:0] act_alarm_in,
  input wire logic loop_phase_lock,
  // Status outputs
  output logic sync_pin,
  output logic irq_req,
  output logic slew_limit_on,
  output logic [NUM_IN-1:0] ref_select,
  output logic [2:0] state_code
);

  localparam int unsigned SELW = (NUM_IN > 1) ? $clog2(NUM_IN) : 1;
  localparam int unsigned TICKW = $clog2(SEC_CYCLES + 1);

  //----------------------------------------------------------------------------
  // Declarations
  //----------------------------------------------------------------------------
  mdsm_pkg::mdsm_cfg_t cfg;
  mdsm_pkg::mdsm_state_t state;
  mdsm_pkg::mdsm_state_t next_state;
  logic [NUM_IN*mdsm_pkg::PRIO_W-1:0] prio;
  logic [NUM_IN-1:0] lock_alarm;
  logic [NUM_IN-1:0] act_latched;
  logic [NUM_IN-1:0] valid;
  logic [SELW-1:0] sel;
  logic [SELW-1:0] next_sel;
  logic [SELW-1:0] best;
  logic best_found;
  logic restart;
  logic set_alarm;
  logic state_chg;
  logic state_latched;
  logic [TICKW-1:0] tick_cnt;
  logic sec_tick;
  logic [15:0] state_secs;
  logic [1:0] lock_secs;
  logic [1:0] inv_secs;
  logic [1:0] decl_secs;
  logic lock_declared;
  logic sel_valid;
  logic other_valid;
  logic timed_out;
  logic qualified;
  logic inv_long;
  logic wr_hit_latched;
  logic wr_hit_alarms;

  //----------------------------------------------------------------------------
  // Helpers
  //----------------------------------------------------------------------------
  // Highest priority valid input: lowest nonzero number, ties to lower index
  function automatic logic [SELW:0] pick_best(
    input logic [NUM_IN-1:0] v,
    input logic [NUM_IN*mdsm_pkg::PRIO_W-1:0] p
  );
    logic [mdsm_pkg::PRIO_W-1:0] bp;
    logic [mdsm_pkg::PRIO_W-1:0] cp;
    logic found;
    logic [SELW-1:0] idx;
    bp = '0;
    cp = '0;
    found = 1'b0;
    idx = '0;
    for (int i = 0; i < NUM_IN; i++) begin
      cp = p[i*mdsm_pkg::PRIO_W +: mdsm_pkg::PRIO_W];
      if (v[i] && (cp != '0) && (!found || cp < bp)) begin
        found = 1'b1;
        bp = cp;
        idx = SELW'(i);
      end
    end
    return {found, idx};
  endfunction : pick_best

  // Software view of a state
  function automatic logic [2:0] code_of(input mdsm_pkg::mdsm_state_t s);
    case (s)
      mdsm_pkg::ST_FREE: code_of = mdsm_pkg::CODE_FREE;
      mdsm_pkg::ST_PRE: code_of = mdsm_pkg::CODE_PRE;
      mdsm_pkg::ST_PRE2: code_of = mdsm_pkg::CODE_PRE2;
      mdsm_pkg::ST_LOCK: code_of = mdsm_pkg::CODE_LOCK;
      mdsm_pkg::ST_LOL: code_of = mdsm_pkg::CODE_LOL;
      mdsm_pkg::ST_HOLD: code_of = mdsm_pkg::CODE_HOLD;
      default: code_of = mdsm_pkg::CODE_FREE;
    endcase
  endfunction : code_of

  // Decoding of a forced code; unknown codes fall to free-run
  function automatic mdsm_pkg::mdsm_state_t state_of(input logic [2:0] c);
    case (c)
      mdsm_pkg::CODE_PRE: state_of = mdsm_pkg::ST_PRE;
      mdsm_pkg::CODE_PRE2: state_of = mdsm_pkg::ST_PRE2;
      mdsm_pkg::CODE_LOCK: state_of = mdsm_pkg::ST_LOCK;
      mdsm_pkg::CODE_LOL: state_of = mdsm_pkg::ST_LOL;
      mdsm_pkg::CODE_HOLD: state_of = mdsm_pkg::ST_HOLD;
      default: state_of = mdsm_pkg::ST_FREE;
    endcase
  endfunction : state_of

  //----------------------------------------------------------------------------
  // Validity and selection
  //----------------------------------------------------------------------------
  // Lock alarm only ever lands on the selected input
  assign valid = ~act_alarm_in & ~lock_alarm;
  assign {best_found, best} = pick_best(valid, prio);
  assign sel_valid = valid[sel];
  assign other_valid = best_found && (best != sel);
  assign timed_out = sec_tick && (state_secs + 16'h0001 >= cfg.timeout_secs);
  assign qualified = lock_declared && (lock_secs >= 2'(mdsm_pkg::QUAL_SECS));
  assign inv_long = inv_secs >= 2'(mdsm_pkg::QUAL_SECS);
  assign wr_hit_latched = reg_wr && (reg_addr == mdsm_pkg::OFS_LATCHED);
  assign wr_hit_alarms = reg_wr && (reg_addr == mdsm_pkg::OFS_ALARMS);

  //----------------------------------------------------------------------------
  // Second prescaler
  //----------------------------------------------------------------------------
  // One pulse per second from the system clock
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt <= '0;
      sec_tick <= 1'b0;
    end else if (tick_cnt == TICKW'(SEC_CYCLES - 1)) begin
      tick_cnt <= '0;
      sec_tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
      sec_tick <= 1'b0;
    end
  end

  // Lock declared only after two tick edges of unbroken loop lock, 1 to 2 s
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      decl_secs <= '0;
    end else if (!loop_phase_lock) begin
      decl_secs <= '0;
    end else if (sec_tick && !lock_declared) begin
      decl_secs <= decl_secs + 1'b1;
    end
  end
  assign lock_declared = decl_secs >= 2'(mdsm_pkg::DECLARE_SECS);

  //----------------------------------------------------------------------------
  // Transition logic
  //----------------------------------------------------------------------------
  // Next state, selection, restart of timers and lock alarm request
  always_comb begin
    next_state = state;
    next_sel = sel;
    restart = 1'b0;
    set_alarm = 1'b0;
    case (state)
      mdsm_pkg::ST_FREE: begin
        if (best_found) begin
          next_state = mdsm_pkg::ST_PRE;
          next_sel = best;
          restart = 1'b1;
        end
      end
      mdsm_pkg::ST_PRE, mdsm_pkg::ST_PRE2: begin
        if (qualified) begin
          next_state = mdsm_pkg::ST_LOCK;
        end else if (cfg.return_to_best_enable && other_valid && sel_valid) begin
          next_sel = best;
          restart = 1'b1;
        end else if (sel_valid && timed_out) begin
          set_alarm = 1'b1;
          restart = 1'b1;
        end else if (!sel_valid && best_found) begin
          next_sel = best;
          restart = 1'b1;
        end else if (!sel_valid && inv_long) begin
          next_state = (state == mdsm_pkg::ST_PRE) ? mdsm_pkg::ST_FREE
                                                   : mdsm_pkg::ST_HOLD;
        end
      end
      mdsm_pkg::ST_LOCK: begin
        if (!sel_valid && best_found) begin
          next_state = mdsm_pkg::ST_PRE2;
          next_sel = best;
          restart = 1'b1;
        end else if (!sel_valid && inv_long) begin
          next_state = mdsm_pkg::ST_HOLD;
        end else if (sel_valid && !lock_declared) begin
          next_state = mdsm_pkg::ST_LOL;
          restart = 1'b1;
        end
      end
      mdsm_pkg::ST_LOL: begin
        if (sel_valid && qualified) begin
          next_state = mdsm_pkg::ST_LOCK;
        end else if (sel_valid && timed_out) begin
          set_alarm = 1'b1;
        end else if (!sel_valid && best_found && (lock_alarm[sel] || inv_long)) begin
          next_state = mdsm_pkg::ST_PRE2;
          next_sel = best;
          restart = 1'b1;
        end else if (!sel_valid && inv_long) begin
          next_state = mdsm_pkg::ST_HOLD;
        end
      end
      mdsm_pkg::ST_HOLD: begin
        if (best_found) begin
          next_state = mdsm_pkg::ST_PRE2;
          next_sel = best;
          restart = 1'b1;
        end
      end
      default: begin
        next_state = mdsm_pkg::ST_FREE;
      end
    endcase
    // A forced state overrides the automatic choice
    if (cfg.force_en) begin
      next_state = state_of(cfg.force_code);
    end
  end

  // State and selected input
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state <= mdsm_pkg::ST_FREE;
      sel <= '0;
      state_chg <= 1'b0;
    end else begin
      state <= next_state;
      sel <= next_sel;
      state_chg <= next_state != state;
    end
  end

  // Timeout seconds, restarted on every state entry or retry
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_secs <= '0;
    end else if (restart || next_state != state) begin
      state_secs <= '0;
    end else if (sec_tick && state_secs != '1) begin
      state_secs <= state_secs + 16'h0001;
    end
  end

  // Seconds of declared lock; a drop of lock starts it again
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lock_secs <= '0;
    end else if (restart || !lock_declared) begin
      lock_secs <= '0;
    end else if (sec_tick && lock_secs != '1) begin
      lock_secs <= lock_secs + 1'b1;
    end
  end

  // Seconds the selected input has been invalid
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      inv_secs <= '0;
    end else if (sel_valid || next_sel != sel) begin
      inv_secs <= '0;
    end else if (sec_tick && inv_secs != '1) begin
      inv_secs <= inv_secs + 1'b1;
    end
  end

  //----------------------------------------------------------------------------
  // Alarms
  //----------------------------------------------------------------------------
  // Sticky alarms; a hardware set beats a software clear in the same cycle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lock_alarm <= '0;
      act_latched <= '0;
    end else begin
      for (int i = 0; i < NUM_IN; i++) begin
        if (set_alarm && sel == SELW'(i)) begin
          lock_alarm[i] <= 1'b1;
        end else if (wr_hit_alarms && reg_wdata[i]) begin
          lock_alarm[i] <= 1'b0;
        end
        if (act_alarm_in[i]) begin
          act_latched[i] <= 1'b1;
        end else if (wr_hit_alarms && reg_wdata[NUM_IN+i]) begin
          act_latched[i] <= 1'b0;
        end
      end
    end
  end

  // Latched state-change bit, cleared by writing one
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_latched <= 1'b0;
    end else if (state_chg) begin
      state_latched <= 1'b1;
    end else if (wr_hit_latched && reg_wdata[0]) begin
      state_latched <= 1'b0;
    end
  end

  //----------------------------------------------------------------------------
  // Configuration registers
  //----------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cfg <= '0;
      cfg.freq_limit_setting <= mdsm_pkg::FREQ_LIMIT_RST;
      cfg.timeout_secs <= mdsm_pkg::TIMEOUT_RST;
      prio <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        mdsm_pkg::OFS_MODE_FIRST: begin
          cfg.force_en <= reg_wdata[mdsm_pkg::FORCE_EN_BIT];
          cfg.force_code <= reg_wdata[2:0];
          cfg.sync_pin_enable <= reg_wdata[mdsm_pkg::SYNC_PIN_BIT];
        end
        mdsm_pkg::OFS_MODE_THIRD: cfg.return_to_best_enable <= reg_wdata[0];
        mdsm_pkg::OFS_MODE_TENTH: cfg.phase_buildout_enable <= reg_wdata[0];
        mdsm_pkg::OFS_FREQ_LIMIT: cfg.freq_limit_setting <= reg_wdata[7:0];
        mdsm_pkg::OFS_TIMEOUT: cfg.timeout_secs <= reg_wdata[15:0];
        mdsm_pkg::OFS_IRQ_EN: cfg.irq_en <= reg_wdata[0];
        mdsm_pkg::OFS_PRIO: prio <= reg_wdata[NUM_IN*mdsm_pkg::PRIO_W-1:0];
        default: ;
      endcase
    end
  end

  //----------------------------------------------------------------------------
  // Read port
  //----------------------------------------------------------------------------
  // Data stand one cycle after the strobe, else zero
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= '0;
    end else if (!reg_rd) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= '0;
      case (reg_addr)
        mdsm_pkg::OFS_MODE_FIRST: begin
          reg_rdata[2:0] <= cfg.force_code;
          reg_rdata[mdsm_pkg::FORCE_EN_BIT] <= cfg.force_en;
          reg_rdata[mdsm_pkg::SYNC_PIN_BIT] <= cfg.sync_pin_enable;
        end
        mdsm_pkg::OFS_MODE_THIRD: reg_rdata[0] <= cfg.return_to_best_enable;
        mdsm_pkg::OFS_MODE_TENTH: reg_rdata[0] <= cfg.phase_buildout_enable;
        mdsm_pkg::OFS_FREQ_LIMIT: reg_rdata[7:0] <= cfg.freq_limit_setting;
        mdsm_pkg::OFS_TIMEOUT: reg_rdata[15:0] <= cfg.timeout_secs;
        mdsm_pkg::OFS_OPERATING_STATE_REG: reg_rdata[2:0] <= code_of(state);
        mdsm_pkg::OFS_LATCHED: reg_rdata[0] <= state_latched;
        mdsm_pkg::OFS_ALARMS: reg_rdata[2*NUM_IN-1:0] <= {act_latched, lock_alarm};
        mdsm_pkg::OFS_VALID: reg_rdata[NUM_IN-1:0] <= valid;
        mdsm_pkg::OFS_IRQ_EN: reg_rdata[0] <= cfg.irq_en;
        mdsm_pkg::OFS_PRIO: reg_rdata[NUM_IN*mdsm_pkg::PRIO_W-1:0] <= prio;
        mdsm_pkg::OFS_SELREF: reg_rdata[SELW-1:0] <= sel;
        default: reg_rdata <= '0;
      endcase
    end
  end

  //----------------------------------------------------------------------------
  // Output flops
  //----------------------------------------------------------------------------
  // All outputs registered; state outputs one cycle behind the state, irq_req two cycles
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync_pin <= 1'b0;
      irq_req <= 1'b0;
      slew_limit_on <= 1'b0;
      ref_select <= '0;
      state_code <= mdsm_pkg::CODE_FREE;
    end else begin
      sync_pin <= cfg.sync_pin_enable && state == mdsm_pkg::ST_LOCK;
      irq_req <= cfg.irq_en && state_latched;
      // Slope limiter in the loop is engaged by this level
      slew_limit_on <= cfg.phase_buildout_enable ||
                       (cfg.freq_limit_setting < mdsm_pkg::SLEW_PPM_LIMIT);
      ref_select <= (state == mdsm_pkg::ST_FREE || state == mdsm_pkg::ST_HOLD)
                    ? '0 : NUM_IN'(1) << sel;
      state_code <= code_of(state);
    end
  end

endmodule : mdsm_main_loop

// ===== dv/mdsm_main_loop_checker.sv
// Port checker of the main loop
`timescale 1ns/1ps
module mdsm_main_loop_checker #(
  parameter int unsigned NUM_IN = 4,
  parameter int unsigned SEC_CYCLES = mdsm_pkg::SEC_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Monitor and status
  input wire logic loop_phase_lock,
  input wire logic sync_pin,
  input wire logic [NUM_IN-1:0] ref_select,
  input wire logic [2:0] state_code
);
  logic frc;
  logic frc_q;
  logic frc_qq;
  logic pin_en;
  logic unforced;
  int unsigned lock_run;
  // Shadow of force and pin enable
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      frc <= 1'b0;
      pin_en <= 1'b0;
    end else if (reg_wr && reg_addr == mdsm_pkg::OFS_MODE_FIRST) begin
      frc <= reg_wdata[mdsm_pkg::FORCE_EN_BIT];
      pin_en <= reg_wdata[mdsm_pkg::SYNC_PIN_BIT];
    end
  end
  // History of force so release settles before moves are judged
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      frc_q <= 1'b0;
      frc_qq <= 1'b0;
    end else begin
      frc_q <= frc;
      frc_qq <= frc_q;
    end
  end
  // Unbroken raw lock length, saturating
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) lock_run <= 0;
    else if (!loop_phase_lock) lock_run <= 0;
    else if (lock_run < 100000) lock_run <= lock_run + 1;
  end
  assign unforced = !(frc || frc_q || frc_qq);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  a_reset_free: assert property ($rose(arst_n) |-> state_code == mdsm_pkg::CODE_FREE)
    else $error("not free after reset");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("rdata not zero");
  a_rdata_state: assert property ($past(reg_rd) && $past(reg_addr) == mdsm_pkg::OFS_OPERATING_STATE_REG
    && $stable(state_code) |-> reg_rdata == {29'h0, state_code})
    else $error("state read mismatch");
  a_sel_onehot: assert property ($onehot0(ref_select))
    else $error("two refs selected");
  a_free_to_pre: assert property (unforced && $past(arst_n) && $past(state_code) ==
    mdsm_pkg::CODE_FREE && state_code != mdsm_pkg::CODE_FREE |-> state_code == mdsm_pkg::CODE_PRE)
    else $error("bad exit from free-run");
  a_hold_to_pre2: assert property (unforced && $past(arst_n) && $past(state_code) ==
    mdsm_pkg::CODE_HOLD && state_code != mdsm_pkg::CODE_HOLD |-> state_code == mdsm_pkg::CODE_PRE2)
    else $error("bad exit from holdover");
  a_lock_qual: assert property (unforced && $changed(state_code) && state_code ==
    mdsm_pkg::CODE_LOCK |-> lock_run >= 2 * SEC_CYCLES)
    else $error("early lock");
  a_sync_locked: assert property (sync_pin |-> state_code == mdsm_pkg::CODE_LOCK ||
    $past(state_code) == mdsm_pkg::CODE_LOCK)
    else $error("sync pin high unlocked");
  a_sync_when: assert property (pin_en && $past(pin_en, 2) && state_code == mdsm_pkg::CODE_LOCK
    && $past(state_code) == mdsm_pkg::CODE_LOCK |-> sync_pin)
    else $error("sync pin low");
endmodule : mdsm_main_loop_checker

bind mdsm_main_loop mdsm_main_loop_checker #(.NUM_IN(NUM_IN), .SEC_CYCLES(SEC_CYCLES)) i_chk (
  .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .loop_phase_lock(loop_phase_lock),
  .sync_pin(sync_pin), .ref_select(ref_select), .state_code(state_code));

// ===== dv/mdsm_ref_model.sv
// Model of reference inputs and loop lock
`timescale 1ns/1ps
module mdsm_ref_model #(
  parameter int unsigned NUM_IN = 4
) (
  // Clock and commands
  input wire logic clk_sys,
  input wire logic lock_cmd,
  input wire logic [NUM_IN-1:0] fail_cmd,
  input wire logic [7:0] lock_delay,
  // Towards the block
  output logic [NUM_IN-1:0] act_alarm_in,
  output logic loop_phase_lock
);
  logic [7:0] wait_cnt;
  initial begin
    act_alarm_in = '0;
    loop_phase_lock = 1'b0;
    wait_cnt = 8'h00;
  end
  // Lock shows after a settling delay; loss is instant
  always @(posedge clk_sys) begin
    act_alarm_in <= fail_cmd;
    if (!lock_cmd) begin
      wait_cnt <= 8'h00;
      loop_phase_lock <= 1'b0;
    end else if (wait_cnt < lock_delay) wait_cnt <= wait_cnt + 8'h01;
    else loop_phase_lock <= 1'b1;
  end
endmodule : mdsm_ref_model

// ===== dv/main_dpll_mode_state_machine_bench.sv
// Self-checking bench of the main loop
`timescale 1ns/1ps
module main_dpll_mode_state_machine_bench;
  logic clk_sys, arst_n, reg_wr, reg_rd, lock_cmd, sync_pin, irq_req, slew_limit_on;
  logic loop_phase_lock;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, r;
  logic [3:0] fail_cmd, lock_al, act_alarm_in, ref_select;
  logic [2:0] state_code;
  int fails, n_checks;
  mdsm_main_loop #(.NUM_IN(4), .SEC_CYCLES(20)) i_dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .act_alarm_in(act_alarm_in), .loop_phase_lock(loop_phase_lock),
    .sync_pin(sync_pin), .irq_req(irq_req), .slew_limit_on(slew_limit_on),
    .ref_select(ref_select), .state_code(state_code));
  mdsm_ref_model #(.NUM_IN(4)) i_ref (.clk_sys(clk_sys), .lock_cmd(lock_cmd),
    .fail_cmd(fail_cmd), .lock_delay(8'h05), .act_alarm_in(act_alarm_in),
    .loop_phase_lock(loop_phase_lock));
  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic wrap_up();
    if (fails == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask : rd_chk
  // Expected selection: lowest valid index, as priorities rise with index
  function automatic logic [3:0] exp_ref();
    logic [3:0] v;
    v = ~fail_cmd & ~lock_al;
    return v & (~v + 4'h1);
  endfunction : exp_ref
  // Bounded wait; running out counts and ends the run
  task automatic wait_for(input bit on_ref, input logic [3:0] want, input int lim);
    int k;
    logic [3:0] now;
    for (k = 0; k < lim; k++) begin
      now = on_ref ? ref_select : {1'b0, state_code};
      if (now === want) break;
      @(posedge clk_sys);
      #1;
    end
    check(now, want);
    if (k == lim) wrap_up();
  endtask : wait_for
  task automatic drive(input logic lk, input logic [3:0] f);
    @(posedge clk_sys);
    lock_cmd <= lk;
    fail_cmd <= f;
    #1;
  endtask : drive
  // Timeout 8 s, irq on, input 0 best, sync pin enabled
  task automatic setup();
    wr(mdsm_pkg::OFS_TIMEOUT, 32'h8);
    wr(mdsm_pkg::OFS_IRQ_EN, 32'h1);
    wr(mdsm_pkg::OFS_PRIO, 32'h4321);
    wr(mdsm_pkg::OFS_MODE_FIRST, 32'h10);
  endtask : setup
  // Main sequence
  initial begin
    {arst_n, reg_wr, reg_rd, lock_cmd, reg_addr, reg_wdata} = '0;
    fail_cmd = 4'hF;
    lock_al = 4'h0;
    fails = 0;
    n_checks = 0;
    r = $urandom(67);
    repeat (10) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd_chk(mdsm_pkg::OFS_OPERATING_STATE_REG, 32'h1);
    rd_chk(mdsm_pkg::OFS_TIMEOUT, 32'h64);
    rd_chk(8'h40, 32'h0);
    check(slew_limit_on, 1'b1);
    r = 32'h1E + $urandom_range(0, 200);
    wr(mdsm_pkg::OFS_FREQ_LIMIT, r);
    rd_chk(mdsm_pkg::OFS_FREQ_LIMIT, r);
    check(slew_limit_on, 1'b0);
    wr(mdsm_pkg::OFS_MODE_TENTH, 32'h1);
    rd_chk(mdsm_pkg::OFS_MODE_TENTH, 32'h1);
    check(slew_limit_on, 1'b1);
    setup();
    drive(1'b1, 4'h0);
    wait_for(0, mdsm_pkg::CODE_PRE, 10);
    wait_for(1, exp_ref(), 4);
    wait_for(0, mdsm_pkg::CODE_LOCK, 300);
    check(sync_pin, 1'b1);
    rd_chk(mdsm_pkg::OFS_LATCHED, 32'h1);
    check(irq_req, 1'b1);
    wr(mdsm_pkg::OFS_LATCHED, 32'h1);
    rd_chk(mdsm_pkg::OFS_LATCHED, 32'h0);
    drive(1'b0, 4'h0);
    wait_for(0, mdsm_pkg::CODE_LOL, 20);
    check(sync_pin, 1'b0);
    drive(1'b1, 4'h0);
    wait_for(0, mdsm_pkg::CODE_LOCK, 300);
    drive(1'b0, 4'h0);
    wait_for(0, mdsm_pkg::CODE_LOL, 20);
    wait_for(0, mdsm_pkg::CODE_PRE2, 400);
    lock_al = 4'h1;
    wait_for(1, exp_ref(), 4);
    drive(1'b1, 4'h0);
    wait_for(0, mdsm_pkg::CODE_LOCK, 300);
    drive(1'b1, 4'h2);
    wait_for(0, mdsm_pkg::CODE_PRE2, 20);
    wait_for(1, exp_ref(), 4);
    wait_for(0, mdsm_pkg::CODE_LOCK, 300);
    drive(1'b1, 4'hF);
    repeat (20) @(posedge clk_sys);
    #1 check(state_code, mdsm_pkg::CODE_LOCK);
    wait_for(0, mdsm_pkg::CODE_HOLD, 60);
    check(ref_select, 4'h0);
    wr(mdsm_pkg::OFS_ALARMS, 32'hFF);
    lock_al = 4'h0;
    drive(1'b0, 4'hD);
    wait_for(0, mdsm_pkg::CODE_PRE2, 10);
    wait_for(1, exp_ref(), 4);
    wait_for(0, mdsm_pkg::CODE_HOLD, 400);
    lock_al = 4'h2;
    rd_chk(mdsm_pkg::OFS_VALID, 32'h0);
    wr(mdsm_pkg::OFS_MODE_THIRD, 32'h1);
    drive(1'b0, 4'hB);
    wait_for(0, mdsm_pkg::CODE_PRE2, 10);
    wait_for(1, exp_ref(), 4);
    drive(1'b0, 4'hA);
    wait_for(1, exp_ref(), 20);
    check(state_code, mdsm_pkg::CODE_PRE2);
    wr(mdsm_pkg::OFS_MODE_FIRST, 32'h1A);
    wait_for(0, mdsm_pkg::CODE_HOLD, 10);
    rd_chk(mdsm_pkg::OFS_OPERATING_STATE_REG, 32'h2);
    wr(mdsm_pkg::OFS_MODE_FIRST, 32'h10);
    wait_for(0, mdsm_pkg::CODE_PRE2, 10);
    // Mid-run reset, then prelocked retry
    drive(1'b0, 4'hF);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    lock_al = 4'h0;
    rd_chk(mdsm_pkg::OFS_OPERATING_STATE_REG, 32'h1);
    setup();
    wr(mdsm_pkg::OFS_MODE_THIRD, 32'h1);
    drive(1'b0, 4'hD);
    wait_for(0, mdsm_pkg::CODE_PRE, 10);
    drive(1'b0, 4'hC);
    wait_for(1, exp_ref(), 20);
    lock_al = 4'h1;
    wait_for(1, exp_ref(), 300);
    check(state_code, mdsm_pkg::CODE_PRE);
    wait_for(0, mdsm_pkg::CODE_FREE, 400);
    wrap_up();
  end
endmodule : main_dpll_mode_state_machine_bench
